// [rtl/sdmc_cfg.svh]
// Constants for the SDRAM calibration-read and loop-off sequencing controller.
// Assumes the controller clock is 50 MHz and the DRAM command bus is sampled on its clock.
`ifndef SDMC_CFG_SVH
`define SDMC_CFG_SVH

// Software register offsets
`define SDMC_REG_CTRL      8'h00
`define SDMC_REG_STATUS    8'h04
`define SDMC_REG_PATTERN   8'h08
`define SDMC_REG_MRVAL     8'h0C
// Control fields
`define SDMC_CTRL_CAL      0
`define SDMC_CTRL_CHOP     1
`define SDMC_CTRL_HALF     2
`define SDMC_CTRL_LOOPOFF  3
`define SDMC_CTRL_ODTEN    4
`define SDMC_CTRL_ZQ       5
`define SDMC_CTRL_LOCKED   6
// Mode register field positions and values
`define SDMC_MR1_LOOPOFF   0
`define SDMC_MR3_CALEN     2
`define SDMC_MR_CHOP_OTF   12
`define SDMC_CAS_SIX       4'h6
`define SDMC_MR_RESET      16'h0000
// Timing counts, in link clock cycles
`define SDMC_TMOD          12
`define SDMC_TCKSRE        10
`define SDMC_TCKSRX        10
`define SDMC_TXS           64
`define SDMC_TZQOPER       512
`define SDMC_READ_LAT      6

`endif

// [rtl/sdmc_ctrl.sv]
// Controller that drives DRAM command pins for calibration reads and loop-off entry.
// Assumes the DRAM clock arrives as DCK from outside and commands are launched on its rising edge.
//
// Our own choices: the register offsets and the strobed register port.
`include "sdmc_cfg.svh"
`default_nettype none
module sdmc_ctrl #(
  parameter int TXS_CYC    = `SDMC_TXS,
  parameter int TZQ_CYC    = `SDMC_TZQOPER,
  parameter int READ_LAT   = `SDMC_READ_LAT
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // Software port
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  // DRAM clock input
  input  wire logic        DCK,
  // DRAM command pins
  output logic             CS_N,
  output logic             RAS_N,
  output logic             CAS_N,
  output logic             WE_N,
  output logic             CKE,
  output logic             ODT,
  output logic      [2:0]  BA,
  output logic      [15:0] A,
  // DRAM data lanes
  input  wire logic [7:0]  DQ_IN
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    sdmc_pkg::sdmc_state_e st;
    logic [15:0] cnt;
    logic [3:0]  beat;
    logic [7:0]  ctrl;
    logic [7:0]  pattern;
    logic        busy;
    logic        loop_off;
    logic        done;
    logic        err;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic        cke;
    logic        odt;
    logic [2:0]  ba;
    logic [15:0] a;
    logic [31:0] rdata;
    logic        dck_prev;
    logic [15:0] mrval;
  } sdmc_state_s;

  sdmc_state_s s_q;
  sdmc_state_s s_d;
  logic [1:0]  sync_out;
  logic        dck_s;
  logic [7:0]  dq_s;
  logic        rise;
  logic        fall;

  // ****************************************
  // Link clock and data lanes
  // ****************************************
  // Both come from the device side, so each passes two flops before use.
  // The detected edges trail the pins by about two clocks, well inside
  // the half period of the link clock.
  sdmc_sync #(.W(1)) u_sync_ck (
    .CLK (CLK),
    .RST (RST),
    .D   (DCK),
    .Q   (dck_s)
  );
  sdmc_sync #(.W(8)) u_sync_dq (
    .CLK (CLK),
    .RST (RST),
    .D   (DQ_IN),
    .Q   (dq_s)
  );
  assign sync_out = {dck_s, s_q.dck_prev};
  assign rise     = (sync_out == 2'b10);
  // Read beats come on both link edges
  assign fall     = (sync_out == 2'b01);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d          = s_q;
    s_d.dck_prev = dck_s;
    s_d.rdata    = '0;
    // ****************************************
    // Software port
    // ****************************************
    // Reads answer one cycle later and read zero otherwise
    if (RD) begin
      if (ADDR == `SDMC_REG_CTRL) begin
        s_d.rdata = {24'h000000, s_q.ctrl};
      end else if (ADDR == `SDMC_REG_STATUS) begin
        s_d.rdata = {24'h000000, 2'h0, s_q.cke, s_q.st == sdmc_pkg::ST_IDLE,
                     s_q.err, s_q.done, s_q.loop_off, s_q.busy};
      end else if (ADDR == `SDMC_REG_PATTERN) begin
        s_d.rdata = {24'h000000, s_q.pattern};
      end else if (ADDR == `SDMC_REG_MRVAL) begin
        s_d.rdata = {16'h0000, s_q.mrval};
      end
    end
    // Writes during an operation are dropped, so software polls busy first
    if (WR && !s_q.busy) begin
      if (ADDR == `SDMC_REG_CTRL) begin
        s_d.ctrl = WDATA[7:0];
        s_d.done = 1'b0;
        s_d.err  = 1'b0;
      end else if (ADDR == `SDMC_REG_MRVAL) begin
        s_d.mrval = WDATA[15:0];
      end
    end
    // ****************************************
    // Command sequencer, one step per link rise
    // ****************************************
    if (rise) begin
      // Default on each link rise is a no-operation so nothing is decoded by accident
      s_d.cs_n  = 1'b0;
      s_d.ras_n = 1'b1;
      s_d.cas_n = 1'b1;
      s_d.we_n  = 1'b1;
      s_d.ba    = 3'h0;
      s_d.a     = 16'h0000;
      if (s_q.cnt != 16'h0000) begin
        s_d.cnt = s_q.cnt - 16'h0001;
      end
      case (s_q.st)
        sdmc_pkg::ST_IDLE: begin
          // Deselect while idle keeps the device from seeing stray commands
          s_d.cs_n = 1'b1;
          s_d.busy = 1'b0;
          if (s_q.ctrl[`SDMC_CTRL_CAL] && !s_q.done) begin
            if (!s_q.ctrl[`SDMC_CTRL_LOCKED] || s_q.loop_off) begin
              // Calibration reads need a locked loop; refuse and report at once
              s_d.err  = 1'b1;
              s_d.done = 1'b1;
            end else begin
              s_d.busy = 1'b1;
              s_d.st   = sdmc_pkg::ST_CAL_MR;
            end
          end else if (s_q.ctrl[`SDMC_CTRL_LOOPOFF] && !s_q.loop_off && !s_q.done) begin
            s_d.busy = 1'b1;
            s_d.odt  = 1'b0;
            s_d.st   = sdmc_pkg::ST_OFF_MR1;
          end
        end
        sdmc_pkg::ST_CAL_MR: begin
          // Mode register three, calibration enable, location zero only
          s_d.ras_n = 1'b0;
          s_d.cas_n = 1'b0;
          s_d.we_n  = 1'b0;
          s_d.ba    = 3'h3;
          s_d.a     = 16'h0000;
          s_d.a[`SDMC_MR3_CALEN] = 1'b1;
          s_d.cnt   = 16'(`SDMC_TMOD);
          s_d.st    = sdmc_pkg::ST_CAL_RD;
        end
        sdmc_pkg::ST_CAL_RD: begin
          if (s_q.cnt == 16'h0000) begin
            s_d.ras_n = 1'b1;
            s_d.cas_n = 1'b0;
            s_d.we_n  = 1'b1;
            s_d.a     = 16'h0000;
            s_d.a[2]  = s_q.ctrl[`SDMC_CTRL_CHOP] & s_q.ctrl[`SDMC_CTRL_HALF];
            s_d.a[`SDMC_MR_CHOP_OTF] = ~s_q.ctrl[`SDMC_CTRL_CHOP];
            s_d.beat    = 4'h0;
            s_d.pattern = 8'h00;
            s_d.cnt     = 16'(READ_LAT);
            s_d.st      = sdmc_pkg::ST_CAL_CAP;
          end
        end
        sdmc_pkg::ST_CAL_CAP: begin
          // Only the latency count runs here; beats are taken below on either edge
        end
        sdmc_pkg::ST_CAL_EXIT: begin
          if (s_q.cnt == 16'(`SDMC_TMOD)) begin
            s_d.ras_n = 1'b0;
            s_d.cas_n = 1'b0;
            s_d.we_n  = 1'b0;
            s_d.ba    = 3'h3;
          end
          if (s_q.cnt == 16'h0000) begin
            // Busy drops with done so software may start the next operation at once
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
            s_d.err  = (s_q.ctrl[`SDMC_CTRL_CHOP] ? s_q.pattern[3:0] != 4'hA
                                                 : s_q.pattern != 8'hAA);
            s_d.st   = sdmc_pkg::ST_IDLE;
          end
        end
        sdmc_pkg::ST_OFF_MR1: begin
          s_d.ras_n = 1'b0;
          s_d.cas_n = 1'b0;
          s_d.we_n  = 1'b0;
          s_d.ba    = 3'h1;
          s_d.a[`SDMC_MR1_LOOPOFF] = 1'b1;
          s_d.cnt   = 16'(`SDMC_TMOD);
          s_d.st    = sdmc_pkg::ST_OFF_WMOD;
        end
        sdmc_pkg::ST_OFF_WMOD: begin
          if (s_q.cnt == 16'h0000) begin
            // Self refresh entry is a refresh command with clock enable low
            s_d.ras_n = 1'b0;
            s_d.cas_n = 1'b0;
            s_d.we_n  = 1'b1;
            s_d.cke   = 1'b0;
            s_d.cnt   = 16'(`SDMC_TCKSRE);
            s_d.st    = sdmc_pkg::ST_OFF_SRE;
          end
        end
        sdmc_pkg::ST_OFF_SRE: begin
          if (s_q.cnt == 16'h0000) begin
            s_d.cnt = 16'(`SDMC_TCKSRX);
            s_d.st  = sdmc_pkg::ST_OFF_CKS;
          end
        end
        sdmc_pkg::ST_OFF_CKS: begin
          if (s_q.cnt == 16'h0000) begin
            s_d.st = sdmc_pkg::ST_OFF_SRX;
          end
        end
        sdmc_pkg::ST_OFF_SRX: begin
          // Exit is a no-operation with clock enable rising; it stays high from here
          s_d.cke = 1'b1;
          s_d.odt = 1'b0;
          s_d.cnt = 16'(TXS_CYC);
          s_d.st  = sdmc_pkg::ST_OFF_WXS;
        end
        sdmc_pkg::ST_OFF_WXS: begin
          if (s_q.cnt == 16'h0000) begin
            // Mode register zero with latency six for loop-off operation
            s_d.ras_n = 1'b0;
            s_d.cas_n = 1'b0;
            s_d.we_n  = 1'b0;
            s_d.ba    = 3'h0;
            s_d.a     = s_q.mrval;
            s_d.a[6:4] = 3'(`SDMC_CAS_SIX - 4'h4);
            // Five rises to the second mode set, then a full update delay after it
            s_d.cnt   = 16'(`SDMC_TMOD) + 16'h0004;
            s_d.st    = sdmc_pkg::ST_OFF_MR;
          end
        end
        sdmc_pkg::ST_OFF_MR: begin
          // The count runs on through the second mode set, so it is issued only once
          if (s_q.cnt == 16'(`SDMC_TMOD)) begin
            // Mode register two, write latency six
            s_d.ras_n = 1'b0;
            s_d.cas_n = 1'b0;
            s_d.we_n  = 1'b0;
            s_d.ba    = 3'h2;
            s_d.a[5:3] = 3'(`SDMC_CAS_SIX - 4'h5);
          end else if (s_q.cnt == 16'h0000) begin
            if (s_q.ctrl[`SDMC_CTRL_ZQ]) begin
              s_d.ras_n = 1'b1;
              s_d.cas_n = 1'b1;
              s_d.we_n  = 1'b0;
              s_d.a[10] = 1'b1;
              s_d.cnt   = 16'(TZQ_CYC);
              s_d.st    = sdmc_pkg::ST_OFF_ZQ;
            end else begin
              s_d.st = sdmc_pkg::ST_OFF_WEND;
            end
          end
        end
        sdmc_pkg::ST_OFF_ZQ: begin
          if (s_q.cnt == 16'h0000) begin
            s_d.st = sdmc_pkg::ST_OFF_WEND;
          end
        end
        sdmc_pkg::ST_OFF_WEND: begin
          // Termination returns only once every update delay has run out
          s_d.loop_off = 1'b1;
          s_d.busy     = 1'b0;
          s_d.done     = 1'b1;
          s_d.odt      = s_q.ctrl[`SDMC_CTRL_ODTEN];
          s_d.st       = sdmc_pkg::ST_IDLE;
        end
        default: begin
          s_d.st = sdmc_pkg::ST_IDLE;
        end
      endcase
    end
    // Beat n lands in pattern bit n. The first beat is launched on a link
    // rise, so a fall alone never starts the capture.
    if (s_q.st == sdmc_pkg::ST_CAL_CAP && s_q.cnt == 16'h0000 &&
        (rise || (fall && s_q.beat != 4'h0))) begin
      s_d.pattern[s_q.beat[2:0]] = dq_s[0];
      s_d.beat = s_q.beat + 4'h1;
      if (s_q.beat + 4'h1 >= (s_q.ctrl[`SDMC_CTRL_CHOP] ? 4'h4 : 4'h8)) begin
        // A chopped burst ends after four beats whichever half was asked for
        s_d.cnt = 16'(`SDMC_TMOD);
        s_d.st  = sdmc_pkg::ST_CAL_EXIT;
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s_q       <= '0;
      s_q.st    <= sdmc_pkg::ST_IDLE;
      s_q.cs_n  <= 1'b1;
      s_q.ras_n <= 1'b1;
      s_q.cas_n <= 1'b1;
      s_q.we_n  <= 1'b1;
      s_q.cke   <= 1'b1;
      s_q.mrval <= `SDMC_MR_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign RDATA = s_q.rdata;
  assign CS_N  = s_q.cs_n;
  assign RAS_N = s_q.ras_n;
  assign CAS_N = s_q.cas_n;
  assign WE_N  = s_q.we_n;
  assign CKE   = s_q.cke;
  assign ODT   = s_q.odt;
  assign BA    = s_q.ba;
  assign A     = s_q.a;
endmodule : sdmc_ctrl
`default_nettype wire

// [rtl/sdmc_pkg.sv]
// Types for the SDRAM calibration-read and loop-off controller.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package sdmc_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_CAL_MR, ST_CAL_RD, ST_CAL_CAP, ST_CAL_EXIT,
    ST_OFF_MR1, ST_OFF_WMOD, ST_OFF_SRE, ST_OFF_CKS, ST_OFF_SRX,
    ST_OFF_WXS, ST_OFF_MR, ST_OFF_ZQ, ST_OFF_WEND
  } sdmc_state_e;
  typedef enum logic [2:0] {
    CMD_NOP, CMD_DESEL, CMD_MRS, CMD_READ, CMD_SRE, CMD_SRX, CMD_ZQCL
  } sdmc_cmd_e;
endpackage : sdmc_pkg
`default_nettype wire

// [rtl/sdmc_sync.sv]
// Two-flop synchroniser for inputs from the link clock domain.
// Assumes the input is a level or slow edge relative to CLK.
`include "sdmc_cfg.svh"
`default_nettype none
module sdmc_sync #(
  parameter int W = 1
) (
  input  wire logic         CLK,
  input  wire logic         RST,
  input  wire logic [W-1:0] D,
  output logic      [W-1:0] Q
);
  logic [W-1:0] meta_q;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      meta_q <= '0;
      Q      <= '0;
    end else begin
      meta_q <= D;
      Q      <= meta_q;
    end
  end
endmodule : sdmc_sync
`default_nettype wire

// [tb/sdmc_ctrl_properties.sv]
// Checker on the command pins and software port of sdmc_ctrl.
// Assumes DCK runs near eight CLK cycles a period.
`default_nettype none
module sdmc_ctrl_properties #(
  parameter int TXS_CYC  = 64,
  parameter int TZQ_CYC  = 512,
  parameter int READ_LAT = 6
) (
  // Clock, reset, bus
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic [7:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  // Link
  input wire logic        DCK,
  input wire logic        CS_N,
  input wire logic        RAS_N,
  input wire logic        CAS_N,
  input wire logic        WE_N,
  input wire logic        CKE,
  input wire logic        ODT,
  input wire logic [2:0]  BA,
  input wire logic [15:0] A,
  input wire logic [7:0]  DQ_IN
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        rd_c;
  logic        mrs_c;
  logic [15:0] mr1_q;
  logic [15:0] low_q;
  logic [15:0] hi_q;
  assign rd_c  = !CS_N && RAS_N && !CAS_N && WE_N;
  assign mrs_c = !CS_N && !RAS_N && !CAS_N && !WE_N;
  // hi_q starts saturated so commands soon after reset are not taken for post-exit ones
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      mr1_q <= 16'h0000;
      low_q <= 16'h0000;
      hi_q  <= 16'hFFFF;
    end else begin
      mr1_q <= (mrs_c && BA == 3'h1) ? 16'h0000 : mr1_q + {15'h0, ~&mr1_q};
      low_q <= CKE ? 16'h0000 : low_q + 16'h0001;
      hi_q  <= !CKE ? 16'h0000 : hi_q + {15'h0, ~&hi_q};
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  property p_rd_nib;
    rd_c |-> A[1:0] == 2'h0;
  endproperty
  a_rd_nib: assert property (p_rd_nib)
    else $error("read low column bits set");
  property p_rd_bl8;
    rd_c && A[12] |-> !A[2];
  endproperty
  a_rd_bl8: assert property (p_rd_bl8)
    else $error("full read with column bit two set");
  property p_mr3_loc;
    mrs_c && BA == 3'h3 && A[2] |-> A[1:0] == 2'h0;
  endproperty
  a_mr3_loc: assert property (p_mr3_loc)
    else $error("reserved location selected");
  property p_mr1_idle;
    mrs_c && BA == 3'h1 && A[0] |-> !ODT && CKE;
  endproperty
  a_mr1_idle: assert property (p_mr1_idle)
    else $error("loop disabled while termination on");
  property p_sre_wait;
    $fell(CKE) |-> mr1_q >= 16'd80;
  endproperty
  a_sre_wait: assert property (p_sre_wait)
    else $error("self refresh before update delay");
  property p_srx_wait;
    $rose(CKE) |-> low_q >= 16'd150;
  endproperty
  a_srx_wait: assert property (p_srx_wait)
    else $error("self refresh exit too early");
  property p_cke_hold;
    $rose(CKE) |=> CKE [*8];
  endproperty
  a_cke_hold: assert property (p_cke_hold)
    else $error("clock enable dropped after exit");
  property p_odt_low;
    !CKE || $rose(CKE) |-> !ODT;
  endproperty
  a_odt_low: assert property (p_odt_low)
    else $error("termination high around self refresh");
  property p_xs_wait;
    mrs_c && CKE |-> int'(hi_q) >= 8 * TXS_CYC - 12;
  endproperty
  a_xs_wait: assert property (p_xs_wait)
    else $error("mode set before exit delay");
  property p_rdata_idle;
    !$past(RD) |-> RDATA == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside answer cycle");
endmodule : sdmc_ctrl_properties
bind sdmc_ctrl sdmc_ctrl_properties #(.TXS_CYC(TXS_CYC), .TZQ_CYC(TZQ_CYC), .READ_LAT(READ_LAT)) u_props (
  .CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .DCK(DCK),
  .CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N), .WE_N(WE_N), .CKE(CKE), .ODT(ODT), .BA(BA), .A(A),
  .DQ_IN(DQ_IN));
`default_nettype wire

// [tb/sdmc_dram_model.sv]
// Behavioural DRAM: calibration reads, loop-off latency, self refresh counts.
// Assumes commands are sampled on the rising edge of dck.
`default_nettype none
module sdmc_dram_model #(
  parameter int READ_LAT = 6
) (
  // Clock and reset
  input wire logic        dck,
  input wire logic        rst,
  // Command pins
  input wire logic        cs_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic        cke,
  input wire logic [2:0]  ba,
  input wire logic [15:0] a,
  // Data lanes
  output logic     [7:0]  dq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic cal_q;
  logic off_q;
  logic cke_q;
  int   n_read;
  int   n_sre;
  int   n_srx;
  task automatic send(input logic full, input logic hi, input logic off);
    int b;
    repeat (READ_LAT - (off ? 1 : 0)) @(posedge dck);
    for (int k = 0; k < (full ? 8 : 4); k++) begin
      b = (hi ? 4 : 0) + k;
      dq = {8{b[0]}};
      @(dck);
    end
    // Released lanes show the inverse of the last beat
    dq = 8'h00;
  endtask : send
  initial dq = 8'h00;
  always @(posedge dck or posedge rst) begin
    if (rst) begin
      {cal_q, off_q, cke_q} <= 3'b001;
      {n_read, n_sre, n_srx} <= '0;
    end else begin
      cke_q <= cke;
      if (cke_q && !cke) n_sre <= n_sre + 1;
      if (!cke_q && cke) n_srx <= n_srx + 1;
      // Deselect and no-operation decode to nothing
      if (cke && !cs_n && !ras_n && !cas_n && !we_n) begin
        if (ba == 3'h3) cal_q <= a[2];
        if (ba == 3'h1) off_q <= a[0];
      end
      // Bank bits, a[10] and a[9:3] are ignored on calibration reads
      if (cke && !cs_n && ras_n && !cas_n && we_n && cal_q) begin
        n_read <= n_read + 1;
        fork
          send(a[12], a[2], off_q);
        join_none
      end
    end
  end
endmodule : sdmc_dram_model
`default_nettype wire

// [tb/test_sdmc_ctrl.sv]
// Testbench for sdmc_ctrl against the behavioural DRAM model.
// Assumes the bind in sdmc_ctrl_properties.sv is compiled with it.
`include "sdmc_cfg.svh"
`default_nettype none
module test_sdmc_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK, RST, WR, RD, DCK;
  logic        CS_N, RAS_N, CAS_N, WE_N, CKE, ODT;
  logic [7:0]  ADDR, DQ_IN;
  logic [31:0] WDATA, RDATA;
  logic [2:0]  BA;
  logic [15:0] A;
  int          mismatches = 0;
  int          n_compared = 0;
  // Short exit and calibration waits keep the run brief
  sdmc_ctrl #(.TXS_CYC(4), .TZQ_CYC(4), .READ_LAT(6)) dut (
    .CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .DCK(DCK),
    .CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N), .WE_N(WE_N), .CKE(CKE), .ODT(ODT), .BA(BA), .A(A),
    .DQ_IN(DQ_IN));
  sdmc_dram_model #(.READ_LAT(6)) u_dram (
    .dck(DCK), .rst(RST), .cs_n(CS_N), .ras_n(RAS_N), .cas_n(CAS_N), .we_n(WE_N), .cke(CKE),
    .ba(BA), .a(A), .dq(DQ_IN));
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  initial begin
    DCK = 1'b0;
    #7;
    forever #80 DCK = ~DCK;
  end
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge CLK);
    WR    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLK);
    RD   <= 1'b0;
    #1 d = RDATA;
  endtask : rd
  task automatic wait_done(output logic [31:0] st);
    st = 32'h0;
    for (int i = 0; i < 4000 && st[2] !== 1'b1; i++) rd(`SDMC_REG_STATUS, st);
    chk("done", st[2], 1'b1);
  endtask : wait_done
  task automatic t_reset;
    logic [31:0] v;
    chk("idle pins", {CS_N, CKE, ODT}, 3'b110);
    rd(`SDMC_REG_STATUS, v);
    chk("status", v & 32'h3F, 32'h30);
    rd(8'h10, v);
    chk("unmapped", v, 32'h0);
    wr(`SDMC_REG_MRVAL, 32'h0001);
    rd(`SDMC_REG_MRVAL, v);
    chk("mrval", v, 32'h0001);
    $display("test reset finished");
  endtask : t_reset
  task automatic t_unlocked;
    logic [31:0] v;
    wr(`SDMC_REG_CTRL, 32'h1);
    wait_done(v);
    chk("err", v[3], 1'b1);
    chk("reads", u_dram.n_read, 32'h0);
    $display("test unlocked finished");
  endtask : t_unlocked
  task automatic t_cal;
    logic [31:0] v, m;
    for (int n = 0; n < 3; n++) begin
      // Either chopped half fills the low nibble only
      m = (n == 0) ? 32'hAA : 32'h0A;
      wr(`SDMC_REG_CTRL, 32'h41 | (n > 0 ? 32'h2 : 32'h0) | (n == 2 ? 32'h4 : 32'h0));
      wait_done(v);
      chk("err", v[3], 1'b0);
      rd(`SDMC_REG_PATTERN, v);
      chk("pattern", v, m);
      chk("reads", u_dram.n_read, n + 1);
      chk("cal mode", u_dram.cal_q, 1'b0);
    end
    $display("test calibration finished");
  endtask : t_cal
  task automatic t_loopoff;
    logic [31:0] v;
    // Termination on afterwards and long calibration on the way
    wr(`SDMC_REG_CTRL, 32'h78);
    wait_done(v);
    chk("status", v & 32'h2A, 32'h22);
    chk("odt after", ODT, 1'b1);
    chk("loop off", u_dram.off_q, 1'b1);
    chk("sr entries", u_dram.n_sre, 32'h1);
    chk("sr exits", u_dram.n_srx, 32'h1);
    wr(`SDMC_REG_CTRL, 32'h41);
    wait_done(v);
    chk("cal refused", v[3], 1'b1);
    $display("test loop off finished");
  endtask : t_loopoff
  initial begin
    RST   = 1'b1;
    WR    = 1'b0;
    RD    = 1'b0;
    ADDR  = 8'h00;
    WDATA = 32'h0;
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    t_reset;
    t_unlocked;
    t_cal;
    t_loopoff;
    results;
  end
  initial begin
    #400000;
    mismatches++;
    $display("FAIL watchdog expected finish seen timeout");
    results;
  end
endmodule : test_sdmc_ctrl
`default_nettype wire
